//--- rtl/hbd_debug_unit.sv
`timescale 1ns/1ps
`include "hbd_params.svh"

module hbd_debug_unit #(
    parameter int ADDR_W = 8,
    parameter int NUM_BP = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire hbd_pkg::hbd_fetch_t fetch,
    input wire hbd_pkg::hbd_data_acc_t data_acc,
    input wire logic instr_done,
    input wire logic operands_busy,
    input wire logic single_step_flag,
    input wire logic task_switch,
    input wire logic task_trap_bit,
    input wire logic dreg_access_req,
    input wire logic real_mode,
    input wire logic [1:0] cpl,
    input wire logic handler_entry,
    output hbd_pkg::hbd_exc_t exc,
    output logic dreg_grant,
    output logic dreg_deny,
    output logic hold_issue
);
    import hbd_pkg::*;

    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] bp_addr_r [NUM_BP];
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] status_r;
    logic [31:0] status_nxt;
    logic [31:0] status_set;
    logic [31:0] rdata_nxt;
    hbd_exc_t exc_r;
    hbd_exc_t exc_nxt;
    hbd_dstate_t dst_r;
    hbd_dstate_t dst_nxt;
    logic [NUM_BP-1:0] pend_hits_r;
    logic [NUM_BP-1:0] pend_hits_nxt;
    logic grant_r;
    logic deny_r;
    logic hold_r;

    logic setup;
    logic wr_en;
    logic [NUM_BP-1:0] sel_bp;
    logic sel_stat;
    logic sel_ctrl;
    logic mapped;

    logic [NUM_BP-1:0] arm;
    logic [NUM_BP-1:0] xmatch;
    logic [NUM_BP-1:0] dmatch;
    logic [3:0] lanes [NUM_BP];
    logic x_en_hit;
    logic d_en_hit;
    logic gd;
    logic exact_on;
    logic guard_flt;
    logic priv_ok;
    logic d_trap;
    logic step_trap;
    logic ts_trap;
    logic any_trap;
    logic any_fault;

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign exc = exc_r;
    assign dreg_grant = grant_r;
    assign dreg_deny = deny_r;
    assign hold_issue = hold_r;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_r & pwrite;
    assign gd = ctrl_r[`HBD_CTRL_GD];
    assign exact_on = ctrl_r[`HBD_CTRL_GE] | ctrl_r[`HBD_CTRL_LE];

    always_comb begin
        sel_stat = (paddr == ADDR_W'(`HBD_OFF_STATUS));
        sel_ctrl = (paddr == ADDR_W'(`HBD_OFF_CTRL));
        for (int i = 0; i < NUM_BP; i++) begin
            sel_bp[i] = (paddr == ADDR_W'(`HBD_OFF_BP0 + 4 * i));
        end
        mapped = sel_stat | sel_ctrl | (|sel_bp);
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (sel_stat) begin
            rdata_nxt = status_r;
        end else if (sel_ctrl) begin
            rdata_nxt = ctrl_r;
        end
        for (int i = 0; i < NUM_BP; i++) begin
            if (sel_bp[i]) begin
                rdata_nxt = bp_addr_r[i];
            end
        end
    end

    // answer one cycle after setup: every access has a single wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup & ~pready_r;
            pslverr_r <= setup & ~mapped;
            prdata_r <= (setup & ~pwrite) ? rdata_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_BP; i++) begin
                bp_addr_r[i] <= `HBD_BP_RST;
            end
        end else begin
            for (int i = 0; i < NUM_BP; i++) begin
                if (wr_en && sel_bp[i]) begin
                    bp_addr_r[i] <= pwdata;
                end
            end
        end
    end

    // per-breakpoint comparators
    genvar g;
    generate
        for (g = 0; g < NUM_BP; g++) begin : gen_bp
            logic [1:0] rw;
            logic [1:0] len;
            logic type_ok;
            assign rw = ctrl_r[`HBD_CTRL_FLD + 4 * g +: 2];
            assign len = ctrl_r[`HBD_CTRL_FLD + 4 * g + 2 +: 2];
            assign arm[g] = ctrl_r[2 * g] | ctrl_r[2 * g + 1];
            // field size from size code; undefined code never matches
            assign lanes[g] = (len == `HBD_LEN_1B) ? (4'h1 << bp_addr_r[g][1:0]) :
                              (len == `HBD_LEN_2B) ? (bp_addr_r[g][1] ? 4'hC : 4'h3) :
                              (len == `HBD_LEN_4B) ? 4'hF : 4'h0;
            assign type_ok = (rw == `HBD_RW_RDWR) ||
                             ((rw == `HBD_RW_WR) && data_acc.write);
            // exact start address of the instruction
            assign xmatch[g] = fetch.valid && (rw == `HBD_RW_EXEC) &&
                               (fetch.addr == bp_addr_r[g]);
            // whole or partial overlap of the field
            assign dmatch[g] = data_acc.valid && type_ok &&
                               (data_acc.addr[31:2] == bp_addr_r[g][31:2]) &&
                               (|(lanes[g] & data_acc.be));
        end
    endgenerate

    // resume flag masks the exec hit
    assign x_en_hit = (|(xmatch & arm)) & ~fetch.resume;
    assign d_en_hit = |(dmatch & arm);
    assign guard_flt = dreg_access_req & gd;
    assign priv_ok = real_mode | (cpl == `HBD_CPL_KERNEL);

    // data trap waits for the causing instruction to complete
    assign d_trap = instr_done & ((dst_r == hbd_st_pend) | d_en_hit);
    assign step_trap = instr_done & single_step_flag;
    // trap after the switch, before the first instruction
    assign ts_trap = task_switch & task_trap_bit;
    assign any_trap = d_trap | step_trap | ts_trap;
    // exec hits reported on the fetch itself
    assign any_fault = x_en_hit | guard_flt;

    // traps of the finishing instruction outrank a fault in the same cycle;
    // the core re-presents the faulting fetch or access after the handler
    always_comb begin
        exc_nxt.req = any_trap | any_fault;
        // fault for exec or guard, trap for data
        exc_nxt.fault = any_fault & ~any_trap;
    end

    always_comb begin
        dst_nxt = dst_r;
        pend_hits_nxt = pend_hits_r;
        case (dst_r)
            hbd_st_idle: begin
                if (d_en_hit && !instr_done) begin
                    dst_nxt = hbd_st_pend;
                    // every matching flag, enabled or not
                    pend_hits_nxt = dmatch;
                end
            end
            hbd_st_pend: begin
                if (instr_done) begin
                    dst_nxt = hbd_st_idle;
                    pend_hits_nxt = '0;
                end else if (data_acc.valid && d_en_hit) begin
                    pend_hits_nxt = pend_hits_r | dmatch;
                end
            end
            default: begin
                dst_nxt = hbd_st_idle;
                pend_hits_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_r <= hbd_st_idle;
            pend_hits_r <= '0;
        end else begin
            dst_r <= dst_nxt;
            pend_hits_r <= pend_hits_nxt;
        end
    end

    always_comb begin
        status_set = 32'h0000_0000;
        if (any_trap) begin
            if (d_trap) begin
                status_set[NUM_BP-1:0] = pend_hits_r | (d_en_hit ? dmatch : '0);
            end
            status_set[`HBD_STAT_BS] = step_trap;
            status_set[`HBD_STAT_BT] = ts_trap;
        end else if (any_fault) begin
            if (x_en_hit) begin
                status_set[NUM_BP-1:0] = xmatch;
            end
            status_set[`HBD_STAT_BD] = guard_flt & ~x_en_hit;
        end
    end

    // hardware only sets; a set beats a same-cycle software write
    always_comb begin
        status_nxt = status_r;
        if (wr_en && sel_stat) begin
            status_nxt = pwdata & `HBD_STAT_MASK;
        end
        status_nxt = status_nxt | status_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= `HBD_STAT_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_en && sel_ctrl) begin
            ctrl_nxt = pwdata & `HBD_CTRL_MASK;
        end
        if (task_switch) begin
            ctrl_nxt = ctrl_nxt & ~`HBD_CTRL_LARMS;
            ctrl_nxt[`HBD_CTRL_LE] = 1'b0;
        end
        if (handler_entry) begin
            ctrl_nxt[`HBD_CTRL_GD] = 1'b0;
        end
    end

    // all arms clear out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `HBD_CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_r <= '0;
        end else begin
            exc_r <= exc_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_r <= 1'b0;
            deny_r <= 1'b0;
        end else begin
            // grant only when unguarded and privileged
            grant_r <= dreg_access_req & ~gd & priv_ok & ~any_trap;
            deny_r <= dreg_access_req & ~gd & ~priv_ok & ~any_trap;
        end
    end

    // without exact bits no stall; trap still comes at completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 1'b0;
        end else begin
            // stall next issue while operands move
            hold_r <= exact_on & (operands_busy | data_acc.valid);
        end
    end
endmodule // hbd_debug_unit

//--- rtl/hbd_params.svh
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH

`define HBD_OFF_BP0 8'h00
`define HBD_OFF_STATUS 8'h18
`define HBD_OFF_CTRL 8'h1C
`define HBD_CTRL_LE 8
`define HBD_CTRL_GE 9
`define HBD_CTRL_GD 13
`define HBD_CTRL_FLD 16
`define HBD_CTRL_MASK 32'hFFFF_23FF
`define HBD_CTRL_LARMS 32'h0000_0055
`define HBD_CTRL_RST 32'h0000_0000
`define HBD_STAT_BD 13
`define HBD_STAT_BS 14
`define HBD_STAT_BT 15
`define HBD_STAT_MASK 32'h0000_E00F
`define HBD_STAT_RST 32'h0000_0000
`define HBD_BP_RST 32'h0000_0000
`define HBD_LEN_1B 2'h0
`define HBD_LEN_2B 2'h1
`define HBD_LEN_4B 2'h3
`define HBD_RW_EXEC 2'h0
`define HBD_RW_WR 2'h1
`define HBD_RW_RDWR 2'h3
`define HBD_CPL_KERNEL 2'h0
`endif

//--- rtl/hbd_pkg.sv
package hbd_pkg;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic resume;
    } hbd_fetch_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [3:0] be;
        logic write;
    } hbd_data_acc_t;

    typedef struct packed {
        logic req;
        logic fault;
    } hbd_exc_t;

    typedef enum logic {
        hbd_st_idle,
        hbd_st_pend
    } hbd_dstate_t;
endpackage

//--- test/hbd_core_model.sv
`timescale 1ns/1ps
module hbd_core_model (
    input wire logic pclk,
    output hbd_pkg::hbd_fetch_t fetch,
    output hbd_pkg::hbd_data_acc_t data_acc,
    output logic instr_done,
    output logic operands_busy,
    output logic single_step_flag,
    output logic task_switch,
    output logic task_trap_bit,
    output logic dreg_access_req,
    output logic handler_entry
);
    import hbd_pkg::*;
    initial begin
        {fetch, data_acc, instr_done, operands_busy} = '0;
        {single_step_flag, task_switch, task_trap_bit, dreg_access_req, handler_entry} = '0;
    end
    // released lines show the inverse, not a stale copy
    task automatic fet(input logic [31:0] a, input logic rf);
        @(posedge pclk);
        fetch <= '{1'b1, a, rf};
        @(posedge pclk);
        fetch <= '{1'b0, ~a, ~rf};
    endtask
    task automatic dat(input logic [31:0] a, input logic [3:0] be, input logic w, input int slow);
        @(posedge pclk);
        data_acc <= '{1'b1, a, be, w};
        operands_busy <= 1'b1;
        @(posedge pclk);
        data_acc <= '{1'b0, ~a, ~be, ~w};
        repeat (slow) @(posedge pclk);
        operands_busy <= 1'b0;
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
    endtask
    // k is access, switch, trap bit, step, handler
    task automatic ev(input logic [4:0] k);
        @(posedge pclk);
        {dreg_access_req, task_switch, task_trap_bit, single_step_flag, handler_entry} <= k;
        instr_done <= k[1];
        @(posedge pclk);
        {dreg_access_req, task_switch, task_trap_bit, single_step_flag, handler_entry, instr_done} <= '0;
    endtask
endmodule // hbd_core_model

//--- test/hbd_debug_unit_sva.sv
`timescale 1ns/1ps
module hbd_debug_unit_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire hbd_pkg::hbd_exc_t exc,
    input wire logic dreg_grant,
    input wire logic dreg_deny,
    input wire hbd_pkg::hbd_fetch_t fetch,
    input wire logic instr_done,
    input wire logic single_step_flag,
    input wire logic task_switch,
    input wire logic task_trap_bit,
    input wire logic dreg_access_req,
    input wire logic real_mode,
    input wire logic [1:0] cpl
);
    import hbd_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    grant_cause_a: assert property (dreg_grant |-> $past(dreg_access_req && (real_mode || cpl == 2'h0)))
        else $error("bad grant");
    ring_deny_a: assert property (dreg_access_req && !real_mode && cpl != 2'h0 |=> !dreg_grant)
        else $error("grant outside ring zero");
    grant_excl_a: assert property (!(dreg_grant && dreg_deny))
        else $error("grant with deny");
    access_answer_a: assert property (dreg_access_req |=> dreg_grant || dreg_deny || exc.req)
        else $error("access unanswered");
    task_trap_a: assert property (task_switch && task_trap_bit |=> exc.req && !exc.fault)
        else $error("no switch trap");
    step_trap_a: assert property (instr_done && single_step_flag |=> exc.req && !exc.fault)
        else $error("no step trap");
    fault_cause_a: assert property (exc.req && exc.fault |-> $past(fetch.valid || dreg_access_req))
        else $error("fault without cause");
    trap_cause_a: assert property (exc.req && !exc.fault |-> $past(instr_done || task_switch))
        else $error("trap without cause");
endmodule // hbd_debug_unit_sva

bind hbd_debug_unit hbd_debug_unit_sva i_sva (.pclk(pclk), .presetn(presetn), .exc(exc), .dreg_grant(dreg_grant),
    .dreg_deny(dreg_deny), .fetch(fetch), .instr_done(instr_done), .single_step_flag(single_step_flag),
    .task_switch(task_switch), .task_trap_bit(task_trap_bit), .dreg_access_req(dreg_access_req),
    .real_mode(real_mode), .cpl(cpl));

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
    import hbd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, idn, obz, stp, tsw, ttb, drq, rm, hen;
    logic dgr, dde, hold, w, h, clr;
    logic [1:0] cpl;
    logic [3:0] be;
    logic [4:0] seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, a, ac;
    hbd_fetch_t fe;
    hbd_data_acc_t da;
    hbd_exc_t exc;
    int n_fail, compares, seed, i;
    hbd_debug_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fetch(fe),
        .data_acc(da), .instr_done(idn), .operands_busy(obz), .single_step_flag(stp), .task_switch(tsw),
        .task_trap_bit(ttb), .dreg_access_req(drq), .real_mode(rm), .cpl(cpl), .handler_entry(hen),
        .exc(exc), .dreg_grant(dgr), .dreg_deny(dde), .hold_issue(hold));
    hbd_core_model i_core (.pclk(pclk), .fetch(fe), .data_acc(da), .instr_done(idn), .operands_busy(obz),
        .single_step_flag(stp), .task_switch(tsw), .task_trap_bit(ttb), .dreg_access_req(drq),
        .handler_entry(hen));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // pulses are collected so a one-cycle answer is never missed
    // single writer of seen; clr asks for an empty collection
    always @(posedge pclk) begin
        seen <= clr ? 5'h00 : seen | {hold, dde, dgr, exc.req & ~exc.fault, exc.req & exc.fault};
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cs(input string nm, input logic [4:0] e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(nm, {27'h0, seen}, {27'h0, e});
        clr = 1'b1;
        @(negedge pclk);
        clr = 1'b0;
    endtask
    function automatic logic hit(input logic [1:0] ln, input logic [1:0] rw, input logic [31:0] b,
        input logic [31:0] x, input logic [3:0] m, input logic wr);
        logic [3:0] f;
        f = (ln == 2'h0) ? 4'h1 << b[1:0] : (ln == 2'h1) ? 4'h3 << {b[1], 1'b0} : (ln == 2'h3) ? 4'hF : 4'h0;
        return x[31:2] == b[31:2] && (f & m) != 4'h0 && (rw == 2'h3 || (rw == 2'h1 && wr));
    endfunction
    task automatic end_of_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge pclk);
        n_fail++;
        end_of_test;
    end
    initial begin
        seed = 81;
        clr = 1'b1;
        {presetn, psel, penable, pwrite, paddr, pwdata, cpl} = '0;
        rm = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        clr = 1'b0;
        apb(1'b0, 8'h1C, 32'h0);
        chk("ctrl", rd, 32'h0);
        i_core.fet(32'h0, 1'b0);
        cs("idle fetch", 5'h00);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {31'h0, er}, 32'h1);
        $display("test 1 done");
        a = $random(seed);
        apb(1'b1, 8'h04, a);
        apb(1'b1, 8'h1C, 32'h8);
        i_core.fet(a, 1'b0);
        cs("exec", 5'h01);
        apb(1'b0, 8'h18, 32'h0);
        chk("exec flag", rd, 32'h2);
        i_core.fet(a, 1'b1);
        cs("resume", 5'h00);
        $display("test 2 done");
        a = $random(seed);
        apb(1'b1, 8'h00, a);
        apb(1'b1, 8'h08, a);
        for (i = 0; i < 48; i++) begin
            w = 1'($random(seed));
            be = 4'($random(seed)) | 4'h1;
            ac = {a[31:2] ^ 30'(i[5]), 2'h0};
            apb(1'b1, 8'h18, 32'h0);
            // exact matching only in the middle third: stall must follow it
            apb(1'b1, 8'h1C, {4'h0, i[1:0], i[3:2], 4'h0, i[1:0], i[3:2], 6'h00, i[4], 9'h001});
            i_core.dat(ac, be, w, 1 + i % 3);
            h = hit(i[1:0], i[3:2], a, ac, be, w);
            cs("data", {i[4], 2'h0, h, 1'b0});
            apb(1'b0, 8'h18, 32'h0);
            chk("data flags", rd, {28'h0, 1'b0, h, 1'b0, h});
        end
        $display("test 3 done");
        apb(1'b1, 8'h1C, 32'h2000);
        apb(1'b1, 8'h18, 32'h0);
        i_core.ev(5'h10);
        cs("guard", 5'h01);
        i_core.ev(5'h01);
        i_core.ev(5'h10);
        cs("handler", 5'h04);
        apb(1'b0, 8'h18, 32'h0);
        chk("guard flag", rd, 32'h2000);
        // first pass is the ring 3 corner, the rest random mode and ring
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            rm <= (i == 0) ? 1'b0 : 1'($random(seed));
            cpl <= (i == 0) ? 2'h3 : 2'($random(seed));
            i_core.ev(5'h10);
            cs("ring3", (rm || cpl == 2'h0) ? 5'h04 : 5'h08);
        end
        @(posedge pclk);
        rm <= 1'b1;
        $display("test 4 done");
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h1C, 32'h3FF);
        i_core.ev(5'h0C);
        cs("switch", 5'h02);
        apb(1'b0, 8'h1C, 32'h0);
        chk("ctrl", rd, 32'h2AA);
        apb(1'b0, 8'h18, 32'h0);
        chk("switch flag", rd, 32'h8000);
        apb(1'b1, 8'h18, 32'h0);
        i_core.ev(5'h02);
        cs("step", 5'h02);
        apb(1'b0, 8'h18, 32'h0);
        chk("step flag", rd, 32'h4000);
        $display("test 5 done");
        end_of_test;
    end
endmodule // tb
